// *** include/pcg_pkg.sv ***
// package: register map, field positions and constants of the pll clock generator registers
`default_nettype none
package pcg_pkg;
   localparam int HADDR_W = 32;
   localparam int HDATA_W = 32;

   // register byte offsets
   localparam logic [31:0] PCG_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] PCG_BW_OFS   = 32'h0000_0004;
   localparam logic [31:0] PCG_PROG_OFS = 32'h0000_0008;

   // decoded register index
   localparam logic [1:0] IDX_CTRL = 2'h0;
   localparam logic [1:0] IDX_BW   = 2'h1;
   localparam logic [1:0] IDX_PROG = 2'h2;
   localparam logic [1:0] IDX_NONE = 2'h3;

   // pll_control_reg fields
   localparam int CTRL_IE_BIT    = 7;
   localparam int CTRL_FLAG_BIT  = 6;
   localparam int CTRL_PLL_POWER_ON_BIT = 5;
   localparam int CTRL_BCS_BIT   = 4;
   localparam logic [3:0] CTRL_LOW_ONES = 4'hF;

   // bandwidth_control_reg fields
   localparam int BW_AUTO_BIT = 7;
   localparam int BW_LOCK_BIT = 6;
   localparam int BW_ACQ_BIT  = 5;
   localparam int BW_XLD_BIT  = 4;
   localparam logic [3:0] BW_TEST_READ = 4'h0;

   // pll_programming_reg fields
   localparam int PROG_MUL_HI = 7;
   localparam int PROG_MUL_LO = 4;
   localparam int PROG_VRS_HI = 3;
   localparam int PROG_VRS_LO = 0;

   // values after reset
   localparam logic       RST_IE    = 1'b0;
   localparam logic       RST_FLAG  = 1'b0;
   localparam logic       RST_PLL_POWER_ON = 1'b1;
   localparam logic       RST_BCS   = 1'b0;
   localparam logic       RST_AUTO  = 1'b0;
   localparam logic       RST_ACQ   = 1'b0;
   localparam logic [3:0] RST_MUL   = 4'h6;
   localparam logic [3:0] RST_VRS   = 4'h6;

   // counts
   localparam int SWITCH_EDGES_DEF = 3;
   localparam int XLD_FACTOR       = 4;

   // ahb-lite codes
   localparam logic       HRESP_OKAY = 1'b0;

   typedef enum logic {SEL_RUN, SEL_HOLD} pcg_sel_state_t;
endpackage : pcg_pkg
`default_nettype wire

// *** hw/pcg_regs.sv ***
// pll clock generator control and status registers with an ahb-lite slave port
`default_nettype none
// Notes on behaviour
// (R1) Manual bandwidth mode holds the lock interrupt enable at 0; reset clears it.
// (R2) Lock indicator change sets the flag; flag and enable raise the interrupt.
// (R3) Any read of the control register clears the lock-change flag; reset too. A lock change in the same cycle wins and sets it.
// (R4) Manual mode reads flag and lock as 0 and raises no interrupt.
// (R5) VCO selected keeps PLL power on forced 1; reset sets it.
// (R6) Select bit forced 0 while PLL off or range zero; reset clears it.
// (R7) Select 1 gives VCO clock over two, 0 gives crystal clock over two.
// (R8) After select change, output holds static for three crystal and VCO edges.
// (R9) Four low control bits always read as ones.
// (R10) Bandwidth mode bit: 1 automatic, 0 manual; reset gives manual.
// (R11) Automatic mode lock bit is read-only lock status; reset clears it.
// (R12) Acquisition bit is status in automatic, writable control in manual.
// (R13) Manually written acquisition value is kept through automatic mode.
// (R14) Writing 1 to crystal-loss starts a 4N cycle check of the crystal.
// (R15) Crystal-loss check works only with VCO selected; otherwise reads 0.
// (R16) Software writes zeros to the bandwidth register test bits.
// (R17) Multiplier field sets divider ratio N, zero acting as one; reset 6.
// (R18) While PLL power is on the programming register ignores writes.
// (R19) Range field zero disables PLL and clears select; reset loads 6.
// (R20) Automatic mode sets the flag on each lock change regardless of enable.
// (R21) VCO may be selected without lock; software confirms lock first.
// (R22) No low-power state alters any clock generator setting.
// (R23) Lock and acquisition inputs are synchronised before flag generation.
module pcg_regs
#(
   parameter int SWITCH_EDGES = pcg_pkg::SWITCH_EDGES_DEF
)
(
   input  wire logic                           hclk,
   input  wire logic                           hresetn,
   input  wire logic                           hsel,
   input  wire logic [pcg_pkg::HADDR_W-1:0]    haddr,
   input  wire logic [1:0]                     htrans,
   input  wire logic                           hwrite,
   input  wire logic [2:0]                     hsize,
   input  wire logic [pcg_pkg::HDATA_W-1:0]    hwdata,
   input  wire logic                           hready,
   output var  logic                           hreadyout,
   output var  logic                           hresp,
   output var  logic [pcg_pkg::HDATA_W-1:0]    hrdata,
   input  wire logic                           crystal_clock,
   input  wire logic                           vco_clock,
   input  wire logic                           lock_detect_in,
   input  wire logic                           tracking_status_in,
   output var  logic                           base_clock_out,
   output var  logic                           lock_irq_request,
   output var  logic                           pll_power_enable,
   output var  logic [3:0]                     feedback_divider_ratio,
   output var  logic [3:0]                     vco_range,
   output var  logic                           auto_bandwidth,
   output var  logic                           filter_tracking
);
   import pcg_pkg::*;

   localparam int         SYN_XTAL = 0;
   localparam int         SYN_VCO  = 1;
   localparam int         SYN_LOCK = 2;
   localparam int         SYN_ACQ  = 3;
   localparam logic [1:0] EDGE_LAST = 2'(SWITCH_EDGES);
   default clocking cb_hclk @(posedge hclk); endclocking
   default disable iff (!hresetn);
   if (SWITCH_EDGES < 1 || SWITCH_EDGES > 3)
   begin : g_bad_edges
      $error("SWITCH_EDGES must lie between 1 and 3");
   end
   function automatic logic [1:0] reg_index(input logic [HADDR_W-1:0] a);
      if (a == PCG_CTRL_OFS)
         return IDX_CTRL;
      if (a == PCG_BW_OFS)
         return IDX_BW;
      if (a == PCG_PROG_OFS)
         return IDX_PROG;
      return IDX_NONE;
   endfunction : reg_index
   logic                 hreadyout_r;
   logic                 hresp_r;
   logic [HDATA_W-1:0]   hrdata_r;
   logic                 wr_pend_r;
   logic [1:0]           wr_idx_r;
   logic [3:0]           syn_s1_r;
   logic [3:0]           syn_s2_r;
   logic [3:0]           syn_s3_r;
   logic                 ie_r;
   logic                 flag_r;
   logic                 pll_power_on_r;
   logic                 bcs_r;
   logic                 auto_r;
   logic                 acq_man_r;
   logic                 xld_r;
   logic                 xld_run_r;
   logic [5:0]           xld_cnt_r;
   logic [3:0]           mul_r;
   logic [3:0]           vrs_r;
   pcg_sel_state_t       sel_state_r;
   logic                 sel_applied_r;
   logic [1:0]           xcnt_r;
   logic [1:0]           vcnt_r;
   logic                 base_clock_out_r;
   logic                 addr_ok;
   logic                 rd_take;
   logic                 wr_take;
   logic                 rd_ctrl_take;
   logic                 wr_ctrl;
   logic                 wr_bw;
   logic                 wr_prog;
   logic                 lock_chg;
   logic                 x_edge;
   logic                 v_edge;
   logic                 src_edge;
   logic [3:0]           ratio_n;
   logic [7:0]           ctrl_rd;
   logic [7:0]           bw_rd;
   logic [7:0]           prog_rd;
   logic [7:0]           rd_byte;

   // ahb-lite address phase decode
   assign addr_ok      = hsel && htrans[1] && hready;
   assign rd_take      = addr_ok && !hwrite;
   assign wr_take      = addr_ok && hwrite;
   assign rd_ctrl_take = rd_take && (reg_index(haddr) == IDX_CTRL);
   assign wr_ctrl      = wr_pend_r && (wr_idx_r == IDX_CTRL);
   assign wr_bw        = wr_pend_r && (wr_idx_r == IDX_BW);
   assign wr_prog      = wr_pend_r && (wr_idx_r == IDX_PROG);

   assign x_edge   = syn_s2_r[SYN_XTAL] && !syn_s3_r[SYN_XTAL];
   assign v_edge   = syn_s2_r[SYN_VCO] && !syn_s3_r[SYN_VCO];
   assign src_edge = sel_applied_r ? v_edge : x_edge;
   assign lock_chg = auto_r && (syn_s2_r[SYN_LOCK] != syn_s3_r[SYN_LOCK]); // R20
   assign ratio_n  = (mul_r == 4'h0) ? 4'h1 : mul_r; // R17

   assign ctrl_rd = {ie_r, flag_r && auto_r, pll_power_on_r, bcs_r, CTRL_LOW_ONES}; // R4 R9
   assign bw_rd   = {auto_r,
                     auto_r && syn_s2_r[SYN_LOCK], // R4 R11
                     auto_r ? syn_s2_r[SYN_ACQ] : acq_man_r, // R12
                     xld_r && bcs_r, // R15
                     BW_TEST_READ};
   assign prog_rd = {mul_r, vrs_r};

   always_comb
   begin
      rd_byte = 8'h00;
      unique case (reg_index(haddr))
         IDX_CTRL: rd_byte = ctrl_rd;
         IDX_BW:   rd_byte = bw_rd;
         IDX_PROG: rd_byte = prog_rd;
         IDX_NONE: rd_byte = 8'h00;
      endcase
   end

   // bus slave: zero-wait reads, one wait state on writes so a following read sees new data
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r   <= 1'b0;
         wr_idx_r    <= IDX_NONE;
         hreadyout_r <= 1'b1;
         hresp_r     <= HRESP_OKAY;
         hrdata_r    <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_r   <= wr_take;
         hreadyout_r <= !wr_take;
         hresp_r     <= HRESP_OKAY;
         if (wr_take)
            wr_idx_r <= reg_index(haddr);
         if (rd_take)
            hrdata_r <= {24'h00_0000, rd_byte};
      end
   end

   // crystal, vco, lock and acquisition inputs cross into hclk
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         syn_s1_r <= 4'h0;
         syn_s2_r <= 4'h0;
         syn_s3_r <= 4'h0;
      end
      else
      begin
         syn_s1_r <= {tracking_status_in, lock_detect_in, vco_clock, crystal_clock}; // R23
         syn_s2_r <= syn_s1_r;
         syn_s3_r <= syn_s2_r;
      end
   end

   // interrupt enable, only writable in automatic mode
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ie_r <= RST_IE; // R1
      else if (!auto_r)
         ie_r <= 1'b0; // R1
      else if (wr_ctrl)
         ie_r <= hwdata[CTRL_IE_BIT];
   end

   // lock-change flag: a new lock change wins over the read clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_r <= RST_FLAG;
      else if (lock_chg)
         flag_r <= 1'b1; // R2 R20
      else if (rd_ctrl_take || !auto_r)
         flag_r <= 1'b0; // R3 R4
   end

   // power and select interlock; old values used so both cannot move in one write
   // no low-power input reaches this block, so settings survive standby untouched (R22)
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pll_power_on_r <= RST_PLL_POWER_ON; // R5
      else if (bcs_r)
         pll_power_on_r <= 1'b1; // R5
      else if (wr_ctrl)
         pll_power_on_r <= hwdata[CTRL_PLL_POWER_ON_BIT];
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         bcs_r <= RST_BCS; // R6
      else if (!pll_power_on_r || vrs_r == 4'h0)
         bcs_r <= 1'b0; // R6 R19
      else if (wr_ctrl)
         // select may not rise in the same write that turns power off
         bcs_r <= hwdata[CTRL_BCS_BIT] && (bcs_r || hwdata[CTRL_PLL_POWER_ON_BIT]); // R6 R21
   end

   // bandwidth mode and manual acquisition value; test bits are dropped (R16)
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         auto_r    <= RST_AUTO; // R10
         acq_man_r <= RST_ACQ; // R12
      end
      else if (wr_bw)
      begin
         auto_r <= hwdata[BW_AUTO_BIT]; // R10
         if (!auto_r)
            acq_man_r <= hwdata[BW_ACQ_BIT]; // R13
      end
   end

   // crystal-loss check: any crystal edge inside the 4N window clears the bit
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         xld_r     <= 1'b0;
         xld_run_r <= 1'b0;
         xld_cnt_r <= 6'h00;
      end
      else if (!bcs_r)
      begin
         xld_r     <= 1'b0; // R15
         xld_run_r <= 1'b0;
         xld_cnt_r <= 6'h00;
      end
      else if (wr_bw && hwdata[BW_XLD_BIT])
      begin
         xld_r     <= 1'b1; // R14
         xld_run_r <= 1'b1;
         xld_cnt_r <= 6'(32'(ratio_n) * XLD_FACTOR); // R14
      end
      else if (xld_run_r)
      begin
         if (x_edge)
            xld_r <= 1'b0; // R14
         if (xld_cnt_r == 6'h01)
            xld_run_r <= 1'b0;
         xld_cnt_r <= 6'(xld_cnt_r - 6'h01);
      end
   end

   // programming register, locked while powered
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mul_r <= RST_MUL; // R17
         vrs_r <= RST_VRS; // R19
      end
      else if (wr_prog && !pll_power_on_r)
      begin
         mul_r <= hwdata[PROG_MUL_HI:PROG_MUL_LO]; // R18
         vrs_r <= hwdata[PROG_VRS_HI:PROG_VRS_LO]; // R18
      end
   end

   // base clock: source over two, frozen while the switch waits on both clocks
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sel_state_r      <= SEL_RUN;
         sel_applied_r    <= 1'b0;
         xcnt_r           <= 2'h0;
         vcnt_r           <= 2'h0;
         base_clock_out_r <= 1'b0;
      end
      else
      begin
         unique case (sel_state_r)
            SEL_RUN:
            begin
               if (bcs_r != sel_applied_r)
               begin
                  sel_state_r <= SEL_HOLD; // R8
                  xcnt_r      <= 2'h0;
                  vcnt_r      <= 2'h0;
               end
               else if (src_edge)
                  base_clock_out_r <= !base_clock_out_r; // R7
            end
            SEL_HOLD:
            begin
               if (x_edge && xcnt_r != EDGE_LAST)
                  xcnt_r <= 2'(xcnt_r + 2'h1); // R8
               if (v_edge && vcnt_r != EDGE_LAST)
                  vcnt_r <= 2'(vcnt_r + 2'h1); // R8
               if (xcnt_r == EDGE_LAST && vcnt_r == EDGE_LAST)
               begin
                  sel_applied_r <= bcs_r;
                  sel_state_r   <= SEL_RUN;
               end
            end
         endcase
      end
   end

   // registered outputs toward the analog pll and the cpu
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lock_irq_request       <= 1'b0;
         pll_power_enable       <= 1'b0;
         feedback_divider_ratio <= 4'h1;
         vco_range              <= 4'h0;
         auto_bandwidth         <= 1'b0;
         filter_tracking        <= 1'b0;
      end
      else
      begin
         lock_irq_request       <= flag_r && ie_r && auto_r; // R2 R4
         pll_power_enable       <= pll_power_on_r && (vrs_r != 4'h0); // R19
         feedback_divider_ratio <= ratio_n; // R17
         vco_range              <= vrs_r;
         auto_bandwidth         <= auto_r;
         filter_tracking        <= auto_r ? syn_s2_r[SYN_ACQ] : acq_man_r; // R12
      end
   end
   assign hreadyout      = hreadyout_r;
   assign hresp          = hresp_r;
   assign hrdata         = hrdata_r;
   assign base_clock_out = base_clock_out_r;
   AST_IE_MANUAL: assert property (!auto_r |=> !ie_r) // R1
      else $error("lock interrupt enable set in manual mode");
   AST_IRQ: assert property ((flag_r && ie_r && auto_r) |=> lock_irq_request) // R2
      else $error("interrupt request missing for flag and enable");
   AST_FLAG_CLR: assert property ((rd_ctrl_take && !lock_chg) |=> !flag_r) // R3
      else $error("control read did not clear lock-change flag");
   AST_MANUAL_READ: assert property ((rd_take && reg_index(haddr) == IDX_BW && !auto_r) // R4
      |=> !hrdata_r[BW_LOCK_BIT]) else $error("lock bit read as 1 in manual mode");
   AST_PLL_POWER_ON_HELD: assert property (bcs_r |-> pll_power_on_r) // R5
      else $error("pll power off while vco selected");
   AST_BCS_FORCED: assert property ((!pll_power_on_r || vrs_r == 4'h0) |=> !bcs_r) // R6
      else $error("select bit set with pll off or range zero");
   AST_SWITCH_TOGGLE: assert property (sel_state_r == SEL_RUN && bcs_r == sel_applied_r // R7
      && src_edge |=> base_clock_out_r != $past(base_clock_out_r))
      else $error("base output missed a source edge");
   AST_BASE_STATIC: assert property (sel_state_r == SEL_HOLD |=> $stable(base_clock_out_r)) // R8
      else $error("base output moved during source switch");
   AST_LOW_ONES: assert property ((rd_take && reg_index(haddr) == IDX_CTRL) // R9
      |=> hrdata_r[3:0] == 4'hF) else $error("control low bits not read as ones");
   AST_XLD_ZERO: assert property ((rd_take && reg_index(haddr) == IDX_BW && !bcs_r) // R15
      |=> !hrdata_r[BW_XLD_BIT]) else $error("crystal-loss read 1 with crystal selected");
   AST_DIV_RATIO: assert property (mul_r == 4'h0 |=> feedback_divider_ratio == 4'h1) // R17
      else $error("zero multiplier not treated as one");
   AST_PROG_LOCK: assert property (pll_power_on_r |=> $stable(mul_r) && $stable(vrs_r)) // R18
      else $error("programming register changed while powered");
   AST_FLAG_SET: assert property (lock_chg |=> flag_r) // R20
      else $error("lock change did not set flag");
endmodule : pcg_regs
`default_nettype wire

// *** tb/pcg_pll_model.sv ***
// behavioural model of the analog pll side: crystal, vco and lock detector
`default_nettype none
module pcg_pll_model
(
   input  wire logic xtal_run,
   input  wire logic vco_run,
   input  wire logic locked,
   input  wire logic tracking,
   output var  logic crystal_clock,
   output var  logic vco_clock,
   output var  logic lock_detect_in,
   output var  logic tracking_status_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial crystal_clock = 1'b0;
   initial vco_clock = 1'b0;
   // a stopped source stands low, as a dead crystal or vco would
   always #50 crystal_clock = xtal_run & ~crystal_clock;
   always #60 vco_clock = vco_run & ~vco_clock;
   // levels change with no relation to the bus clock
   assign lock_detect_in = locked;
   assign tracking_status_in = tracking;
endmodule : pcg_pll_model
`default_nettype wire

// *** tb/tb.sv ***
// self-checking testbench of the pll clock generator registers
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcg_pkg::*;
   typedef struct packed
   {
      logic [31:0] a;
      logic [7:0]  wd;
      logic [7:0]  rd;
      logic        pwr;
      logic [3:0]  n;
   } pcg_row_t;
   logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [HADDR_W-1:0] haddr;
   logic [1:0]         htrans;
   logic [2:0]         hsize;
   logic [HDATA_W-1:0] hwdata, hrdata;
   logic               crystal_clock, vco_clock, lock_detect_in, tracking_status_in;
   logic               base_clock_out, lock_irq_request, pll_power_enable;
   logic [3:0]         feedback_divider_ratio, vco_range;
   logic               auto_bandwidth, filter_tracking;
   logic               xtal_run, vco_run, locked, tracking;
   int                 miscompares, checks, c;
   pcg_row_t           rows [14] = '{
      '{PCG_PROG_OFS, 8'h00, 8'h66, 1'b1, 4'h6}, '{PCG_CTRL_OFS, 8'h80, 8'h0F, 1'b0, 4'h6},
      '{PCG_PROG_OFS, 8'h30, 8'h30, 1'b0, 4'h3}, '{PCG_CTRL_OFS, 8'h30, 8'h2F, 1'b0, 4'h3},
      '{PCG_CTRL_OFS, 8'h30, 8'h2F, 1'b0, 4'h3}, '{PCG_CTRL_OFS, 8'h00, 8'h0F, 1'b0, 4'h3},
      '{PCG_PROG_OFS, 8'h04, 8'h04, 1'b0, 4'h1}, '{PCG_PROG_OFS, 8'h24, 8'h24, 1'b0, 4'h2},
      '{PCG_CTRL_OFS, 8'h20, 8'h2F, 1'b1, 4'h2}, '{PCG_CTRL_OFS, 8'h10, 8'h0F, 1'b0, 4'h2},
      '{PCG_CTRL_OFS, 8'h20, 8'h2F, 1'b1, 4'h2}, '{PCG_CTRL_OFS, 8'h30, 8'h3F, 1'b1, 4'h2},
      '{PCG_CTRL_OFS, 8'h10, 8'h3F, 1'b1, 4'h2}, '{PCG_BW_OFS, 8'h20, 8'h20, 1'b1, 4'h2}};
   assign hready = hreadyout;
   pcg_regs #(.SWITCH_EDGES(3)) i_pcg_regs
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock), .lock_detect_in(lock_detect_in),
      .tracking_status_in(tracking_status_in), .base_clock_out(base_clock_out),
      .lock_irq_request(lock_irq_request), .pll_power_enable(pll_power_enable),
      .feedback_divider_ratio(feedback_divider_ratio), .vco_range(vco_range),
      .auto_bandwidth(auto_bandwidth), .filter_tracking(filter_tracking)
   );
   pcg_pll_model i_pcg_pll_model
   (
      .xtal_run(xtal_run), .vco_run(vco_run), .locked(locked), .tracking(tracking),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock),
      .lock_detect_in(lock_detect_in), .tracking_status_in(tracking_status_in)
   );
   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   task automatic report_and_stop;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   // address phase held until hready is seen high at an edge
   task automatic addr_ph(input logic [31:0] a, input logic w);
      @(posedge hclk);
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
   endtask : addr_ph
   task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
      addr_ph(a, 1'b1);
      hwdata <= {24'h00_0000, d};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask : bus_wr
   task automatic rd_chk(input logic [31:0] a, input logic [7:0] e, input string nm);
      addr_ph(a, 1'b0);
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      `CHK(nm, {24'h00_0000, e}, hrdata)
      `CHK("hresp", HRESP_OKAY, hresp)
   endtask : rd_chk
   task automatic toggles(input int cyc, output int n);
      logic p;
      n = 0;
      p = base_clock_out;
      repeat (cyc)
      begin
         @(posedge hclk);
         if (base_clock_out !== p)
            n++;
         p = base_clock_out;
      end
   endtask : toggles
   task automatic reset_chk;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      `CHK("pwr in reset", 1'b0, pll_power_enable)
      `CHK("irq in reset", 1'b0, lock_irq_request)
      hresetn <= 1'b1;
      rd_chk(PCG_CTRL_OFS, 8'h2F, "ctrl reset");
      rd_chk(PCG_BW_OFS, 8'h00, "bw reset");
      rd_chk(PCG_PROG_OFS, 8'h66, "prog reset");
      rd_chk(32'h0000_000C, 8'h00, "unmapped");
      `CHK("pwr", 1'b1, pll_power_enable)
      `CHK("n reset", 4'h6, feedback_divider_ratio)
      `CHK("range reset", 4'h6, vco_range)
      `CHK("auto reset", 1'b0, auto_bandwidth)
      `CHK("trk reset", 1'b0, filter_tracking)
   endtask : reset_chk
   initial
   begin
      #1_000_000;
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = '0;
      xtal_run = 1'b1;
      vco_run = 1'b1;
      locked = 1'b0;
      tracking = 1'b0;
      miscompares = 0;
      checks = 0;
      reset_chk();
      foreach (rows[i])
      begin
         bus_wr(rows[i].a, rows[i].wd);
         rd_chk(rows[i].a, rows[i].rd, "row read");
         `CHK("row pwr", rows[i].pwr, pll_power_enable)
         `CHK("row n", rows[i].n, feedback_divider_ratio)
      end
      // vco selected: output follows the vco with the crystal dead
      xtal_run <= 1'b0;
      repeat (10) @(posedge hclk);
      toggles(100, c);
      `CHK("vco toggles", 1'b1, c inside {[28:38]})
      xtal_run <= 1'b1;
      bus_wr(PCG_BW_OFS, 8'h30);
      repeat (12) @(posedge hclk);
      rd_chk(PCG_BW_OFS, 8'h20, "xld live");
      xtal_run <= 1'b0;
      repeat (4) @(posedge hclk);
      bus_wr(PCG_BW_OFS, 8'h30);
      repeat (12) @(posedge hclk);
      rd_chk(PCG_BW_OFS, 8'h30, "xld dead");
      // back to crystal while it is stopped: the hold lasts until the crystal restarts
      bus_wr(PCG_CTRL_OFS, 8'h20);
      rd_chk(PCG_BW_OFS, 8'h20, "xld off");
      toggles(50, c);
      `CHK("hold toggles", 0, c)
      xtal_run <= 1'b1;
      repeat (20) @(posedge hclk);
      vco_run <= 1'b0;
      repeat (4) @(posedge hclk);
      toggles(100, c);
      `CHK("xtal toggles", 1'b1, c inside {[35:45]})
      vco_run <= 1'b1;
      // automatic mode, lock events and the interrupt
      bus_wr(PCG_BW_OFS, 8'hA0);
      rd_chk(PCG_BW_OFS, 8'h80, "auto bw");
      `CHK("auto", 1'b1, auto_bandwidth)
      `CHK("trk status", 1'b0, filter_tracking)
      tracking <= 1'b1;
      repeat (6) @(posedge hclk);
      rd_chk(PCG_BW_OFS, 8'hA0, "acq status");
      bus_wr(PCG_CTRL_OFS, 8'hA0);
      rd_chk(PCG_CTRL_OFS, 8'hAF, "ie auto");
      locked <= 1'b1;
      repeat (8) @(posedge hclk);
      `CHK("irq", 1'b1, lock_irq_request)
      rd_chk(PCG_CTRL_OFS, 8'hEF, "flag set");
      rd_chk(PCG_CTRL_OFS, 8'hAF, "flag clr");
      `CHK("irq clr", 1'b0, lock_irq_request)
      rd_chk(PCG_BW_OFS, 8'hE0, "lock");
      bus_wr(PCG_CTRL_OFS, 8'h20);
      locked <= 1'b0;
      repeat (8) @(posedge hclk);
      `CHK("irq off", 1'b0, lock_irq_request)
      rd_chk(PCG_CTRL_OFS, 8'h6F, "flag no ie");
      bus_wr(PCG_BW_OFS, 8'h00);
      rd_chk(PCG_BW_OFS, 8'h20, "acq kept");
      `CHK("trk kept", 1'b1, filter_tracking)
      locked <= 1'b1;
      repeat (8) @(posedge hclk);
      rd_chk(PCG_CTRL_OFS, 8'h2F, "manual flag");
      `CHK("manual irq", 1'b0, lock_irq_request)
      reset_chk();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
